// >>> core/scm_core.sv
// sequencer, setup selection and correction equations of the sensor math
`timescale 1ns/100ps
`default_nettype none
`include "scm_params.svh"
module scm_core (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic reset_pin_n,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	output logic cmd_ready,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic meas_req,
	output logic [15:0] afe_cfg,
	input wire logic raw_valid,
	input wire scm_pkg::scm_word_t sensor_raw,
	input wire scm_pkg::scm_word_t temp_raw,
	input wire logic curve_shape_select,
	input wire logic alt_no_correction,
	input wire scm_pkg::scm_word_t gain_coeff,
	input wire scm_pkg::scm_word_t offset_coeff,
	input wire scm_pkg::scm_word_t gain_drift_coeff,
	input wire scm_pkg::scm_word_t offset_drift_coeff,
	input wire scm_pkg::scm_word_t gain_drift_square_coeff,
	input wire scm_pkg::scm_word_t offset_drift_square_coeff,
	input wire scm_pkg::scm_word_t sensor_square_coeff,
	input wire scm_pkg::scm_word_t sensor_shift_coeff,
	output logic alt_setup_active,
	output logic result_valid,
	output scm_pkg::scm_word_t result_sensor,
	output scm_pkg::scm_word_t result_temp,
	output logic [7:0] result_status
);
	import scm_pkg::*;

	scm_mul_if mul ();
	scm_mulsat #(.W(26)) u_mul (.m(mul));

	// bounded sum: returns {overflow flag, clamped 26-bit value}
	function automatic logic [26:0] lim(
		input logic signed [27:0] v,
		input logic signed [27:0] lo,
		input logic signed [27:0] hi
	);
		logic signed [27:0] r;
		logic f;
		r = v;
		f = 1'b0;
		if (v > hi) begin
			r = hi;
			f = 1'b1;
		end else if (v < lo) begin
			r = lo;
			f = 1'b1;
		end
		return {f, r[25:0]};
	endfunction

	// coefficient or raw word, sign-extended and held to plus/minus 7ffff
	function automatic scm_w26_t coef(input logic [23:0] x);
		logic signed [27:0] v;
		v = {{4{x[23]}}, x};
		if (v > `SCM_COEF_MAX) begin
			v = `SCM_COEF_MAX;
		end else if (v < `SCM_COEF_MIN) begin
			v = `SCM_COEF_MIN;
		end
		return v[25:0];
	endfunction

	function automatic logic signed [27:0] x28(input logic signed [25:0] x);
		return {{2{x[25]}}, x};
	endfunction

	scm_state_e state_r, state_nxt;
	logic [2:0] step_r, step_nxt;
	logic sel_r, sel_nxt;
	logic [15:0] setup_pri_r, setup_pri_nxt;
	logic [15:0] setup_alt_r, setup_alt_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [15:0] cfg_r, cfg_nxt;
	scm_w26_t sraw_r, sraw_nxt;
	scm_w26_t traw_r, traw_nxt;
	scm_w26_t acc_r, acc_nxt;
	scm_w26_t k1_r, k1_nxt;
	scm_w26_t k2_r, k2_nxt;
	scm_w26_t z_r, z_nxt;
	logic sat_r, sat_nxt;
	logic curve_r, curve_nxt;
	logic valid_r, valid_nxt;
	scm_word_t sout_r, sout_nxt;
	scm_word_t tout_r, tout_nxt;
	logic [7:0] status_r, status_nxt;

	logic any_rst;
	logic cmd_take;
	logic is_meas;
	logic bypass;
	logic [26:0] l1, l2;
	logic signed [27:0] pw;

	assign any_rst = rst || !reset_pin_n;
	assign cmd_ready = (state_r == SCM_IDLE);
	assign cmd_take = cmd_valid && cmd_ready;
	assign is_meas = (cmd_code >= `SCM_CMD_MEAS_LO) && (cmd_code <= `SCM_CMD_MEAS_HI);
	// alternate setup without its own coefficient set: raw data is handed through
	assign bypass = sel_r && alt_no_correction;
	assign pw = x28(mul.p);

	// setup selection and the register file
	always_comb begin
		sel_nxt = sel_r;
		setup_pri_nxt = setup_pri_r;
		setup_alt_nxt = setup_alt_r;
		rdata_nxt = rdata_r;
		if (cmd_take && cmd_code == `SCM_CMD_SEL_ALT) begin
			sel_nxt = SCM_SEL_ALT;
		end else if (cmd_take && cmd_code == `SCM_CMD_SEL_PRI) begin
			sel_nxt = SCM_SEL_PRI;
		end
		if (reg_wr && reg_addr == `SCM_OFS_SETUP_PRI) begin
			setup_pri_nxt = reg_wdata;
		end
		if (reg_wr && reg_addr == `SCM_OFS_SETUP_ALT) begin
			setup_alt_nxt = reg_wdata;
		end
		if (reg_rd) begin
			case (reg_addr)
				`SCM_OFS_SETUP_PRI: rdata_nxt = setup_pri_r;
				`SCM_OFS_SETUP_ALT: rdata_nxt = setup_alt_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			sel_r <= SCM_SEL_PRI;
			setup_pri_r <= `SCM_SETUP_RST;
			setup_alt_r <= `SCM_SETUP_RST;
			rdata_r <= 16'h0000;
		end else begin
			sel_r <= sel_nxt;
			setup_pri_r <= setup_pri_nxt;
			setup_alt_r <= setup_alt_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// measurement sequencer: one multiplier, eight steps
	always_comb begin
		state_nxt = state_r;
		step_nxt = step_r;
		cfg_nxt = cfg_r;
		sraw_nxt = sraw_r;
		traw_nxt = traw_r;
		acc_nxt = acc_r;
		k1_nxt = k1_r;
		k2_nxt = k2_r;
		z_nxt = z_r;
		sat_nxt = sat_r;
		curve_nxt = curve_r;
		valid_nxt = 1'b0;
		sout_nxt = sout_r;
		tout_nxt = tout_r;
		status_nxt = status_r;
		mul.a = '0;
		mul.b = '0;
		mul.sh = `SCM_SH_UNIT;
		l1 = '0;
		l2 = '0;
		case (state_r)
			SCM_IDLE: begin
				if (cmd_take && is_meas) begin
					state_nxt = SCM_WAIT_RAW;
					cfg_nxt = sel_r ? setup_alt_r : setup_pri_r;
				end
			end
			SCM_WAIT_RAW: begin
				if (raw_valid) begin
					sraw_nxt = coef(sensor_raw[23:0]);
					traw_nxt = coef(temp_raw[23:0]);
					curve_nxt = curve_shape_select;
					sat_nxt = 1'b0;
					step_nxt = 3'h0;
					if (bypass) begin
						// raw word leaves untouched, no scaling and no clamping
						sout_nxt = sensor_raw;
						tout_nxt = temp_raw;
						status_nxt = 8'h00;
						valid_nxt = 1'b1;
						state_nxt = SCM_IDLE;
					end else begin
						state_nxt = SCM_CALC;
					end
				end
			end
			SCM_CALC: begin
				step_nxt = step_r + 3'h1;
				case (step_r)
					3'h0: begin
						mul.a = coef(gain_drift_square_coeff);
						mul.b = traw_r;
						mul.sh = `SCM_SH_COEF;
						l1 = lim(pw + (x28(coef(gain_drift_coeff)) <<< 2), `SCM_MIN25, `SCM_MAX25);
						acc_nxt = l1[25:0];
					end
					3'h1: begin
						mul.a = traw_r;
						mul.b = acc_r;
						l1 = lim(`SCM_ONE + pw, `SCM_MIN25, `SCM_MAX25);
						k1_nxt = l1[25:0];
					end
					3'h2: begin
						mul.a = coef(offset_drift_square_coeff);
						mul.b = traw_r;
						mul.sh = `SCM_SH_COEF;
						l1 = lim(pw + (x28(coef(offset_drift_coeff)) <<< 2), `SCM_MIN25, `SCM_MAX25);
						acc_nxt = l1[25:0];
					end
					3'h3: begin
						mul.a = traw_r;
						mul.b = acc_r;
						l1 = lim(x28(sraw_r) + pw, `SCM_MIN25, `SCM_MAX25);
						l2 = lim((x28(coef(offset_coeff)) <<< 2) + x28(l1[25:0]), `SCM_MIN25,
							`SCM_MAX25);
						k2_nxt = l2[25:0];
					end
					3'h4: begin
						mul.a = k1_r;
						mul.b = k2_r;
						acc_nxt = mul.p;
					end
					3'h5: begin
						mul.a = coef(gain_coeff);
						mul.b = acc_r;
						mul.sh = `SCM_SH_COEF;
						if (curve_r) begin
							z_nxt = mul.p;
						end else begin
							l1 = lim(pw + `SCM_ONE, `SCM_ZERO, `SCM_MAX25);
							z_nxt = l1[25:0];
						end
					end
					3'h6: begin
						mul.a = coef(sensor_square_coeff);
						mul.sh = `SCM_SH_COEF;
						// curve 1 bends on the magnitude, giving the S shape
						if (curve_r && z_r[25]) begin
							l2 = lim(-x28(z_r), `SCM_MIN25, `SCM_MAX25);
							mul.b = l2[25:0];
						end else begin
							mul.b = z_r;
						end
						l1 = lim(pw + `SCM_ONE, `SCM_MIN25, `SCM_MAX25);
						acc_nxt = l1[25:0];
					end
					3'h7: begin
						mul.a = z_r;
						mul.b = acc_r;
						// S-shaped result is centred on 2^23, parabolic on zero
						l1 = lim(pw + x28(coef(sensor_shift_coeff)) + (curve_r ? `SCM_ONE : `SCM_ZERO),
							`SCM_ZERO, `SCM_OUT_MAX);
						sout_nxt = l1[23:0];
						tout_nxt = traw_r[23:0];
						status_nxt = 8'h00;
						status_nxt[`SCM_SAT_BIT] = sat_r || l1[26] || l2[26] || mul.sat;
						valid_nxt = 1'b1;
						state_nxt = SCM_IDLE;
					end
					default: begin
						state_nxt = SCM_IDLE;
					end
				endcase
				if (l1[26] || l2[26] || mul.sat) begin
					sat_nxt = 1'b1;
				end
			end
			default: begin
				state_nxt = SCM_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			state_r <= SCM_IDLE;
			step_r <= 3'h0;
			cfg_r <= 16'h0000;
			sraw_r <= '0;
			traw_r <= '0;
			acc_r <= '0;
			k1_r <= '0;
			k2_r <= '0;
			z_r <= '0;
			sat_r <= 1'b0;
			curve_r <= 1'b0;
			valid_r <= 1'b0;
			sout_r <= '0;
			tout_r <= '0;
			status_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			step_r <= step_nxt;
			cfg_r <= cfg_nxt;
			sraw_r <= sraw_nxt;
			traw_r <= traw_nxt;
			acc_r <= acc_nxt;
			k1_r <= k1_nxt;
			k2_r <= k2_nxt;
			z_r <= z_nxt;
			sat_r <= sat_nxt;
			curve_r <= curve_nxt;
			valid_r <= valid_nxt;
			sout_r <= sout_nxt;
			tout_r <= tout_nxt;
			status_r <= status_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign meas_req = (state_r == SCM_WAIT_RAW);
	assign afe_cfg = cfg_r;
	assign alt_setup_active = sel_r;
	assign result_valid = valid_r;
	assign result_sensor = sout_r;
	assign result_temp = tout_r;
	assign result_status = status_r;

	pin_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
		!reset_pin_n |=> !alt_setup_active && state_r == SCM_IDLE)
		else $error("pin reset did not restore primary setup");
	sel_hold_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		!alt_setup_active && !(cmd_take && cmd_code == `SCM_CMD_SEL_ALT) |=> !alt_setup_active)
		else $error("primary setup left without select command");
	sel_primary_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		cmd_take && cmd_code == `SCM_CMD_SEL_PRI |=> !alt_setup_active)
		else $error("primary select command ignored");
	cfg_choice_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		cmd_take && is_meas |=> meas_req && afe_cfg == (alt_setup_active ?
			setup_alt_r : setup_pri_r))
		else $error("wrong analog setup applied");
	calc_len_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		meas_req && raw_valid && !bypass |=> !result_valid [*8] ##1 result_valid)
		else $error("correction result not after nine cycles");
	bypass_out_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		meas_req && raw_valid && bypass |=> result_valid &&
			result_sensor == $past(sensor_raw) && result_status == 8'h00)
		else $error("raw pass-through altered the reading");
	sat_clear_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		meas_req && raw_valid |=> !sat_r)
		else $error("saturation not cleared at measurement start");
	sat_sticky_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		state_r == SCM_CALC && mul.sat |=> sat_r || result_status[`SCM_SAT_BIT])
		else $error("clamped product not flagged");
	sat_report_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		state_r == SCM_CALC && step_r == `SCM_LAST_STEP && sat_r |=>
			result_valid && result_status[`SCM_SAT_BIT])
		else $error("saturation missing from result status");
	mul_bound_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		mul.sat |-> mul.p == 26'sh1ffffff || mul.p == 26'sh2000000)
		else $error("saturated product not at a limit");
	z_positive_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		state_r == SCM_CALC && step_r == 3'h5 && !curve_r |=> !z_r[25])
		else $error("parabolic intermediate went negative");
endmodule
`default_nettype wire

// >>> core/scm_params.svh
// constants of the sensor correction math datapath
// Function
// - correct-measurement commands AA..AF return sensor and temperature results; temperature is the raw reading, clamped to +/-7FFFF unless no-correction
// - primary analog setup is active by default without any command
// - command B0 makes the primary setup active for later measurements
// - any reset returns selection to primary; host must re-send B1
// - no-correction option passes auto-zeroed raw sensor reading straight out; here only while the alternate setup is selected
// - status bit 0 reports intermediate saturation; final output still delivered
// - every bounded term clamps to its limits and flags saturation, except the coefficient and raw-reading limits, which clamp without a flag
// - curve select 0 picks parabolic, 1 picks S-shaped compensation
// - coefficients and raw readings are signed, limited to plus/minus 7FFFF
// - K1 = 2^23 + T/2^23 * (4*gain drift square * T/2^23 + 4*gain drift)
// - K2 = 4*offset + S raw + T/2^23*(4*offset drift square*T/2^23 + 4*offset drift)
// - parabolic Z = 4*gain/2^23 * K1/2^23 * K2 + 2^23, kept positive
// - parabolic S = Z/2^23*(4*square coeff*Z/2^23 + 2^23) + shift, non-negative
// - S-shaped Z = gain/2^21 * [K1/2^23*K2], both bounded signed 26 bit
// - S-shaped S = Z/2^23*(square/2^21*|Z| + 2^23) + 2^23 + shift, 0..2^24-1
// - corrected outputs are always 24-bit words
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH
`define SCM_OFS_SETUP_PRI 8'h12
`define SCM_OFS_SETUP_ALT 8'h16
`define SCM_SETUP_RST 16'h0000
`define SCM_CMD_MEAS_LO 8'haa
`define SCM_CMD_MEAS_HI 8'haf
`define SCM_CMD_SEL_PRI 8'hb0
`define SCM_CMD_SEL_ALT 8'hb1
`define SCM_SAT_BIT 0
`define SCM_ONE 28'sh0800000
`define SCM_MAX25 28'sh1ffffff
`define SCM_MIN25 28'she000000
`define SCM_OUT_MAX 28'sh0ffffff
`define SCM_ZERO 28'sh0000000
`define SCM_COEF_MAX 28'sh007ffff
`define SCM_COEF_MIN 28'shff80001
`define SCM_SH_COEF 5'd21
`define SCM_SH_UNIT 5'd23
`define SCM_LAST_STEP 3'h7
`define SCM_CALC_CYCLES 9
`endif

// >>> core/scm_pkg.sv
// types of the sensor correction math datapath
package scm_pkg;
	typedef logic signed [25:0] scm_w26_t;
	typedef logic [23:0] scm_word_t;
	typedef enum logic [1:0] {
		SCM_IDLE = 2'b00,
		SCM_WAIT_RAW = 2'b01,
		SCM_CALC = 2'b10
	} scm_state_e;
	typedef enum logic {
		SCM_SEL_PRI = 1'b0,
		SCM_SEL_ALT = 1'b1
	} scm_setup_e;
endpackage

// >>> core/scm_mul_if.sv
// operands and bounded product between the sequencer and the multiplier
`timescale 1ns/100ps
`default_nettype none
interface scm_mul_if;
	scm_pkg::scm_w26_t a;
	scm_pkg::scm_w26_t b;
	logic [4:0] sh;
	scm_pkg::scm_w26_t p;
	logic sat;
	modport master(output a, output b, output sh, input p, input sat);
	modport unit(input a, input b, input sh, output p, output sat);
endinterface
`default_nettype wire

// >>> core/scm_mulsat.sv
// signed multiply, arithmetic shift and clamp to the signed W-bit range
`timescale 1ns/100ps
`default_nettype none
module scm_mulsat #(
	parameter int W = 26
) (
	scm_mul_if.unit m
);
	import scm_pkg::*;
	logic signed [2*W-1:0] prod;
	logic signed [2*W-1:0] shd;
	logic ovf;

	if (W != $bits(scm_w26_t)) begin : g_bad_width
		$error("scm_mulsat width must match the datapath word");
	end

	always_comb begin
		prod = (2*W)'(m.a) * (2*W)'(m.b);
		shd = prod >>> m.sh;
		// the value fits only when all bits above the sign position agree
		ovf = !((&shd[2*W-1:W-1]) || !(|shd[2*W-1:W-1]));
		if (ovf) begin
			m.p = shd[2*W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
		end else begin
			m.p = shd[W-1:0];
		end
		m.sat = ovf;
	end
endmodule
`default_nettype wire

// >>> testbench/scm_afe_model.sv
// analog front-end model that answers conversion requests of the correction core
`timescale 1ns/100ps
`default_nettype none
module scm_afe_model (
	input wire logic ref_clk,
	input wire logic meas_req,
	input wire logic [3:0] dly,
	input wire scm_pkg::scm_word_t s_val,
	input wire scm_pkg::scm_word_t t_val,
	output logic raw_valid,
	output scm_pkg::scm_word_t sensor_raw,
	output scm_pkg::scm_word_t temp_raw
);
	int cnt = 0;
	initial begin
		raw_valid = 1'b0;
		sensor_raw = 24'h000000;
		temp_raw = 24'h000000;
	end
	// moves half a step before the bench; released data is inverted so no stale word can pass
	always @(posedge ref_clk) begin
		#0.5;
		if (raw_valid) begin
			raw_valid = 1'b0;
			sensor_raw = ~sensor_raw;
			temp_raw = ~temp_raw;
			cnt = 0;
		end else if (meas_req && cnt < int'(dly)) begin
			cnt++;
		end else if (meas_req) begin
			raw_valid = 1'b1;
			sensor_raw = s_val;
			temp_raw = t_val;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/sensor_correction_math_test.sv
// self-checking bench of the sensor correction math core
`timescale 1ns/100ps
`default_nettype none
module sensor_correction_math_test;
	import scm_pkg::*;
	logic ref_clk, rst, reset_pin_n, cmd_valid, reg_wr, reg_rd, curve, no_corr;
	logic cmd_ready, meas_req, alt_setup_active, result_valid, raw_valid;
	logic [7:0] cmd_code, reg_addr, result_status;
	logic [15:0] reg_wdata, reg_rdata, afe_cfg;
	logic [3:0] dly;
	scm_word_t s_val, t_val, sensor_raw, temp_raw, result_sensor, result_temp;
	scm_word_t gain, ofs, gdr, odr, gsq, osq, ssq, shift;
	scm_word_t g_tab[4] = '{24'h040000, 24'h040000, 24'hfc0000, 24'hfc0000};
	scm_word_t e_tab[4] = '{24'h903223, 24'h802819, 24'h8fcdbf, 24'h7fd7c6};
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;

	scm_core DUT (.ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .meas_req(meas_req), .afe_cfg(afe_cfg),
		.raw_valid(raw_valid), .sensor_raw(sensor_raw), .temp_raw(temp_raw),
		.curve_shape_select(curve), .alt_no_correction(no_corr),
		.gain_coeff(gain), .offset_coeff(ofs), .gain_drift_coeff(gdr),
		.offset_drift_coeff(odr), .gain_drift_square_coeff(gsq),
		.offset_drift_square_coeff(osq), .sensor_square_coeff(ssq),
		.sensor_shift_coeff(shift), .alt_setup_active(alt_setup_active),
		.result_valid(result_valid), .result_sensor(result_sensor),
		.result_temp(result_temp), .result_status(result_status));

	scm_afe_model afe (.ref_clk(ref_clk), .meas_req(meas_req), .dly(dly), .s_val(s_val),
		.t_val(t_val), .raw_valid(raw_valid), .sensor_raw(sensor_raw), .temp_raw(temp_raw));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// a whole measurement takes some 20 cycles, so this only trips on a hang
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, cyc, 0);
			end_sim();
		end
	end

	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		// an idle edge first, so a strobe is never lowered and raised in one time step
		tick();
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		tick();
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		tick();
		reg_rd = 1'b1;
		reg_addr = a;
		tick();
		reg_rd = 1'b0;
		chk(reg_rdata, e);
	endtask

	task automatic cmd(input logic [7:0] c);
		int n;
		n = 0;
		tick();
		while (cmd_ready !== 1'b1 && n < 64) begin
			tick();
			n++;
		end
		cmd_valid = 1'b1;
		cmd_code = c;
		tick();
		cmd_valid = 1'b0;
	endtask

	task automatic measure(input logic [7:0] c, input scm_word_t es, input scm_word_t et,
		input logic [15:0] ecfg, input int lat);
		int n;
		cmd(c);
		chk(meas_req, 1'b1);
		chk(cmd_ready, 1'b0);
		chk(afe_cfg, ecfg);
		n = 0;
		while (!(meas_req === 1'b1 && raw_valid === 1'b1) && n < 64) begin
			tick();
			n++;
		end
		n = 0;
		do begin
			tick();
			n++;
		end while (result_valid !== 1'b1 && n < 64);
		chk(24'(n), 24'(lat));
		chk(result_sensor, es);
		chk(result_temp, et);
		chk(result_status, 8'h00);
		tick();
		chk(result_valid, 1'b0);
	endtask

	initial begin
		rst = 1'b1;
		reset_pin_n = 1'b1;
		{cmd_valid, reg_wr, reg_rd, curve, no_corr} = 5'h00;
		{cmd_code, reg_addr, reg_wdata, dly} = 36'h0;
		{gain, ofs, gdr, odr, gsq, osq} = 144'h0;
		ssq = 24'h000100;
		shift = 24'h000010;
		s_val = 24'h001234;
		t_val = 24'h001000;
		repeat (3) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		chk(alt_setup_active, 1'b0);
		rd(8'h12, 16'h0000);
		wr(8'h12, 16'ha5a5);
		wr(8'h16, 16'h5a5a);
		wr(8'h20, 16'hffff);
		rd(8'h12, 16'ha5a5);
		rd(8'h16, 16'h5a5a);
		rd(8'h20, 16'h0000);
		$display("test registers done");
		// zero gain pins Z at unity, so S is unity plus four times the square term plus shift
		for (int c = 8'haa; c <= 8'haf; c++) begin
			dly = 4'(c - 8'haa);
			measure(8'(c), 24'h800410, 24'h001000, 16'ha5a5, 9);
		end
		$display("test command range done");
		cmd(8'hb1);
		chk(alt_setup_active, 1'b1);
		no_corr = 1'b1;
		s_val = 24'hfff000;
		measure(8'haa, 24'hfff000, 24'h001000, 16'h5a5a, 1);
		no_corr = 1'b0;
		measure(8'hab, 24'h800410, 24'h001000, 16'h5a5a, 9);
		cmd(8'hb0);
		chk(alt_setup_active, 1'b0);
		measure(8'hac, 24'h800410, 24'h001000, 16'ha5a5, 9);
		$display("test setup select done");
		cmd(8'hb1);
		reset_pin_n = 1'b0;
		tick();
		reset_pin_n = 1'b1;
		chk(alt_setup_active, 1'b0);
		rd(8'h16, 16'h0000);
		$display("test reset pin done");
		ofs = 24'h001000;
		gdr = 24'h040000;
		odr = 24'h040000;
		ssq = 24'h040000;
		shift = 24'hfffff0;
		s_val = 24'h008000;
		t_val = 24'h040000;
		for (int i = 0; i < 4; i++) begin
			gain = g_tab[i];
			curve = i[0];
			measure(8'haf, e_tab[i], 24'h040000, 16'h0000, 9);
		end
		$display("test correction chain done");
		end_sim();
	end
endmodule
`default_nettype wire
